// ===== modem_control_defines.svh
// timing and configuration constants for the modem control serial port
`ifndef MODEM_CONTROL_DEFINES_SVH
`define MODEM_CONTROL_DEFINES_SVH
`define CLK_HZ 100000000
`define MAX_BAUD 1000000
`define AUTOBAUD_MAX_BAUD 115200
`define DEFAULT_DIVISOR 16'h0364
`define MIN_DIVISOR (`CLK_HZ / `MAX_BAUD)
`define AUTOBAUD_MIN_DIVISOR (`CLK_HZ / `AUTOBAUD_MAX_BAUD)
`define RING_PULSE_US 1000
`define RING_PULSE_CYCLES ((`RING_PULSE_US * (`CLK_HZ / 1000000)))
`define FIFO_DEPTH 16
`define FIFO_ALMOST_FULL_MARGIN 4
`endif

// ===== modem_control_pkg.sv
// types for the modem control serial port
package modem_control_pkg;
    typedef struct packed {
        logic voiceCall;
        logic dataCall;
        logic shortMessage;
    } ring_event_s;

    typedef struct packed {
        logic [15:0] divisor;
        logic autoBaud;
        logic ringEnable;
        logic sleepMode;
    } port_config_s;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } rx_state_e;

    typedef enum logic [3:0] {
        TX_IDLE = 4'b0001,
        TX_START = 4'b0010,
        TX_DATA = 4'b0100,
        TX_STOP = 4'b1000
    } tx_state_e;
endpackage

// ===== modem_control_serial_port.sv
// modem control serial port: uart with full handshake lines and rx fifo
`timescale 1ns/100ps
`default_nettype none
`include "modem_control_defines.svh"

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int MARGIN = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // level
    output logic almostFull
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [AW-1:0] wrPtr, next_wrPtr, rdPtr, next_rdPtr;
    logic [AW:0] count, next_count;
    logic push, pop;

    assign inReady = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData = mem[rdPtr];
    assign almostFull = (count >= (AW+1)'(DEPTH - MARGIN));
    assign push = inValid && inReady;
    assign pop = outValid && outReady;

    always_comb begin
        next_mem = mem;
        next_wrPtr = wrPtr;
        next_rdPtr = rdPtr;
        next_count = count;
        if (push) begin
            next_mem[wrPtr] = inData;
            next_wrPtr = (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
        end
        if (pop) begin
            next_rdPtr = (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            mem <= next_mem;
            wrPtr <= next_wrPtr;
            rdPtr <= next_rdPtr;
            count <= next_count;
        end
    end
endmodule

module modem_control_serial_port
    import modem_control_pkg::*;
#(
    parameter int RING_CYCLES = `RING_PULSE_CYCLES,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // serial pins (levels are active low on the handshake lines)
    input wire logic serial_rx_in,
    output logic serial_tx_out,
    input wire logic host_clear_in,
    output logic module_ready_out,
    input wire logic host_control_in,
    output logic interface_on_out,
    output logic connection_active_out,
    output logic ring_indicate_out,
    // module core side
    input wire logic interfaceOn,
    input wire logic commandReady,
    input wire logic asleep,
    input wire logic connectionActive,
    input wire port_config_s portConfig,
    input wire ring_event_s ringEvent,
    input wire logic txValid,
    output logic txReady,
    input wire logic [7:0] txData,
    output logic rxValid,
    input wire logic rxReady,
    output logic [7:0] rxData,
    output logic framingError,
    output logic hostControl,
    output logic [15:0] activeDivisor
);
    // Functional notes
    // - both ends pace transfers with request and clear flow control
    // - ready output held off until the core can accept a command
    // - ring output pulses on call or message events when enabled
    // - connection output asserted while a packet data session runs
    // - interface-on output driven low while the port is switched on
    // - looped interface-on to set-ready reads as asserted; sleep mode kept
    // - host set-ready line delivered to the core for sleep and mode control
    // - rates up to 1 Mbit/s; auto-baud only up to 115.2 kbit/s
    // - ready output may be asserted while the core sleeps

    // three stage synchronisers, change taken when stages two and three agree
    logic [2:0] rxSync, next_rxSync, ctsSync, next_ctsSync;
    logic [2:0] dsrSync, next_dsrSync;
    logic rxIn, next_rxIn, ctsIn, next_ctsIn, dsrIn, next_dsrIn;

    always_comb begin
        next_rxSync = {rxSync[1:0], serial_rx_in};
        next_ctsSync = {ctsSync[1:0], host_clear_in};
        next_dsrSync = {dsrSync[1:0], host_control_in};
        next_rxIn = (rxSync[1] == rxSync[2]) ? rxSync[2] : rxIn;
        next_ctsIn = (ctsSync[1] == ctsSync[2]) ? ctsSync[2] : ctsIn;
        next_dsrIn = (dsrSync[1] == dsrSync[2]) ? dsrSync[2] : dsrIn;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxSync <= 3'h7;
            ctsSync <= 3'h7;
            dsrSync <= 3'h7;
            rxIn <= 1'b1;
            ctsIn <= 1'b1;
            dsrIn <= 1'b1;
        end else begin
            rxSync <= next_rxSync;
            ctsSync <= next_ctsSync;
            dsrSync <= next_dsrSync;
            rxIn <= next_rxIn;
            ctsIn <= next_ctsIn;
            dsrIn <= next_dsrIn;
        end
    end

    // loopback makes the input follow our own low level, so no special case
    assign hostControl = !dsrIn;

    // divisor clamp: auto-baud top rate while auto-baud is on, otherwise the overall top rate
    logic [15:0] next_activeDivisor;
    always_comb begin
        next_activeDivisor = portConfig.divisor;
        if (portConfig.autoBaud &&
            portConfig.divisor < 16'(`AUTOBAUD_MIN_DIVISOR)) begin
            next_activeDivisor = 16'(`AUTOBAUD_MIN_DIVISOR);
        end else if (portConfig.divisor < 16'(`MIN_DIVISOR)) begin
            next_activeDivisor = 16'(`MIN_DIVISOR);
        end
    end

    // receiver
    rx_state_e rxState, next_rxState;
    logic [15:0] rxCnt, next_rxCnt;
    logic [2:0] rxBit, next_rxBit;
    logic [7:0] rxShift, next_rxShift;
    logic rxPush, fifoReady, almostFull, next_framingError;

    always_comb begin
        next_rxState = rxState;
        next_rxCnt = rxCnt - 1'b1;
        next_rxBit = rxBit;
        next_rxShift = rxShift;
        next_framingError = 1'b0;
        rxPush = 1'b0;
        case (rxState)
            RX_IDLE: begin
                next_rxCnt = {1'b0, activeDivisor[15:1]};
                if (!rxIn) begin
                    next_rxState = RX_START;
                end
            end
            RX_START: begin
                if (rxCnt == '0) begin
                    next_rxCnt = activeDivisor;
                    next_rxBit = '0;
                    next_rxState = rxIn ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (rxCnt == '0) begin
                    next_rxCnt = activeDivisor;
                    next_rxShift = {rxIn, rxShift[7:1]};
                    next_rxBit = rxBit + 1'b1;
                    if (rxBit == 3'h7) begin
                        next_rxState = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (rxCnt == '0) begin
                    next_rxState = RX_IDLE;
                    // a full fifo drops the byte; host should have stopped
                    rxPush = rxIn;
                    next_framingError = !rxIn;
                end
            end
            default: next_rxState = RX_IDLE;
        endcase
    end

    byte_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH),
        .MARGIN(`FIFO_ALMOST_FULL_MARGIN)
    ) rxFifo (
        .clk(clk),
        .reset_n(reset_n),
        .inValid(rxPush),
        .inReady(fifoReady),
        .inData(rxShift),
        .outValid(rxValid),
        .outReady(rxReady),
        .outData(rxData),
        .almostFull(almostFull)
    );

    // transmitter, stalls at byte boundaries while host clear is off
    tx_state_e txState, next_txState;
    logic [15:0] txCnt, next_txCnt;
    logic [2:0] txBit, next_txBit;
    logic [7:0] txShift, next_txShift;
    logic next_serialTx;

    assign txReady = (txState == TX_IDLE) && !ctsIn;

    always_comb begin
        next_txState = txState;
        next_txCnt = txCnt - 1'b1;
        next_txBit = txBit;
        next_txShift = txShift;
        next_serialTx = serial_tx_out;
        case (txState)
            TX_IDLE: begin
                next_serialTx = 1'b1;
                next_txCnt = activeDivisor;
                if (txValid && txReady) begin
                    next_txShift = txData;
                    next_serialTx = 1'b0;
                    next_txState = TX_START;
                end
            end
            TX_START: begin
                if (txCnt == '0) begin
                    next_txCnt = activeDivisor;
                    next_txBit = '0;
                    next_serialTx = txShift[0];
                    next_txState = TX_DATA;
                end
            end
            TX_DATA: begin
                if (txCnt == '0) begin
                    next_txCnt = activeDivisor;
                    next_txBit = txBit + 1'b1;
                    next_txShift = {1'b1, txShift[7:1]};
                    next_serialTx = (txBit == 3'h7) ? 1'b1 : txShift[1];
                    if (txBit == 3'h7) begin
                        next_txState = TX_STOP;
                    end
                end
            end
            TX_STOP: begin
                if (txCnt == '0) begin
                    next_txState = TX_IDLE;
                end
            end
            default: next_txState = TX_IDLE;
        endcase
    end

    // modem control outputs, all active low on the pins
    logic [31:0] ringCnt, next_ringCnt;
    logic next_ready, next_ifOn, next_dcd, next_ri;
    always_comb begin
        next_ringCnt = (ringCnt != '0) ? ringCnt - 1'b1 : ringCnt;
        if (portConfig.ringEnable && (|ringEvent)) begin
            next_ringCnt = 32'(RING_CYCLES);
        end
        // ready does not depend on asleep: sleep may keep it asserted
        next_ready = !(commandReady && interfaceOn && !almostFull
                       && fifoReady);
        next_ifOn = !interfaceOn;
        next_dcd = !connectionActive;
        next_ri = !(ringCnt != '0);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rxState <= RX_IDLE;
            rxCnt <= '0;
            rxBit <= '0;
            rxShift <= '0;
            framingError <= 1'b0;
            txState <= TX_IDLE;
            txCnt <= '0;
            txBit <= '0;
            txShift <= '0;
            serial_tx_out <= 1'b1;
            activeDivisor <= `DEFAULT_DIVISOR;
            ringCnt <= '0;
            module_ready_out <= 1'b1;
            interface_on_out <= 1'b1;
            connection_active_out <= 1'b1;
            ring_indicate_out <= 1'b1;
        end else begin
            rxState <= next_rxState;
            rxCnt <= next_rxCnt;
            rxBit <= next_rxBit;
            rxShift <= next_rxShift;
            framingError <= next_framingError;
            txState <= next_txState;
            txCnt <= next_txCnt;
            txBit <= next_txBit;
            txShift <= next_txShift;
            serial_tx_out <= next_serialTx;
            activeDivisor <= next_activeDivisor;
            ringCnt <= next_ringCnt;
            module_ready_out <= next_ready;
            interface_on_out <= next_ifOn;
            connection_active_out <= next_dcd;
            ring_indicate_out <= next_ri;
        end
    end
endmodule
`default_nettype wire

// ===== serial_port_properties.sv
// pin level assertions for the modem control serial port
`timescale 1ns/100ps
`default_nettype none
module serial_port_properties
    import modem_control_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pins
    input wire logic serial_tx_out,
    input wire logic host_clear_in,
    input wire logic module_ready_out,
    input wire logic host_control_in,
    input wire logic interface_on_out,
    input wire logic connection_active_out,
    input wire logic ring_indicate_out,
    // core side
    input wire logic interfaceOn,
    input wire logic commandReady,
    input wire logic connectionActive,
    input wire port_config_s portConfig,
    input wire ring_event_s ringEvent,
    input wire logic txValid,
    input wire logic txReady,
    input wire logic hostControl,
    input wire logic [15:0] activeDivisor
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    iface_on_a:
        assert property (interfaceOn |=> !interface_on_out)
        else $error("interface on not shown");
    iface_off_a:
        assert property (!interfaceOn |=> interface_on_out)
        else $error("interface off not shown");
    link_up_a:
        assert property (connectionActive |=> !connection_active_out)
        else $error("connection not shown");
    link_down_a:
        assert property (!connectionActive |=> connection_active_out)
        else $error("connection end not shown");
    not_ready_a:
        assert property (!commandReady |=> module_ready_out)
        else $error("ready before commands accepted");
    ring_start_a:
        assert property (portConfig.ringEnable && (|ringEvent)
            |-> ##2 !ring_indicate_out)
        else $error("ring pulse missing");
    tx_hold_a:
        assert property (host_clear_in [*5] |-> !txReady)
        else $error("send allowed while host holds off");
    tx_start_a:
        assert property (txValid && txReady |=> !serial_tx_out && !txReady)
        else $error("start bit missing");
    ctrl_seen_a:
        assert property (!host_control_in [*5] |-> hostControl)
        else $error("host control not seen");
    rate_limit_a:
        assert property (activeDivisor >= 16'h0064)
        else $error("bit rate above limit");
    auto_limit_a:
        assert property ($past(portConfig.autoBaud)
            |-> activeDivisor >= 16'h0364)
        else $error("auto rate above limit");
    cover property ($fell(ring_indicate_out));
    cover property (txValid && txReady);
    cover property ($rose(module_ready_out));
endmodule
bind modem_control_serial_port serial_port_properties
    serial_port_properties_i (.clk(clk), .reset_n(reset_n),
    .serial_tx_out(serial_tx_out), .host_clear_in(host_clear_in),
    .module_ready_out(module_ready_out), .host_control_in(host_control_in),
    .interface_on_out(interface_on_out), .interfaceOn(interfaceOn),
    .connection_active_out(connection_active_out),
    .ring_indicate_out(ring_indicate_out), .commandReady(commandReady),
    .connectionActive(connectionActive), .portConfig(portConfig),
    .ringEvent(ringEvent), .txValid(txValid), .txReady(txReady),
    .hostControl(hostControl), .activeDivisor(activeDivisor));
`default_nettype wire

// ===== host_terminal_model.sv
// host terminal model: serial data and handshake lines toward the module
`timescale 1ns/100ps
`default_nettype none
module host_terminal_model #(
    parameter int BIT_CYCLES = 101
) (
    // clock
    input wire logic clk,
    // from the module
    input wire logic serial_tx_out,
    input wire logic module_ready_out,
    // to the module
    output logic serial_rx_in,
    output logic host_clear_in,
    output logic host_control_in
);
    logic [7:0] gotBytes[$];
    logic [7:0] shift;
    initial begin
        serial_rx_in = 1'b1;
        host_clear_in = 1'b1;
        host_control_in = 1'b1;
    end
    task automatic setLines(input logic clear, input logic control);
        host_clear_in = clear;
        host_control_in = control;
    endtask
    task automatic sendByte(input logic [7:0] b, input logic stopBit);
        logic [9:0] frame;
        frame = {stopBit, b, 1'b0};
        // no sending until the module says it has room
        while (module_ready_out !== 1'b0) @(negedge clk);
        for (int i = 0; i < 10; i++) begin
            serial_rx_in = frame[i];
            // a bad stop is cut short so that no false start follows it
            repeat ((i == 9 && !stopBit) ? BIT_CYCLES * 2 / 3 : BIT_CYCLES)
                @(negedge clk);
        end
        if (!stopBit) begin
            serial_rx_in = 1'b1;
        end
    endtask
    always begin
        @(negedge serial_tx_out);
        repeat (BIT_CYCLES / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk);
            shift[i] = serial_tx_out;
        end
        gotBytes.push_back(shift);
    end
endmodule
`default_nettype wire

// ===== modem_control_serial_port_bench.sv
// self-checking bench for the modem control serial port
`timescale 1ns/100ps
`default_nettype none
module modem_control_serial_port_bench;
    import modem_control_pkg::*;
    localparam int RING = 8;
    logic clk = 1'b0;
    logic reset_n, interfaceOn, commandReady, connectionActive, asleep;
    logic serial_rx_in, serial_tx_out, host_clear_in, module_ready_out;
    logic host_control_in, interface_on_out, connection_active_out;
    logic ring_indicate_out, txValid, txReady, rxValid, rxReady;
    logic framingError, hostControl;
    logic [7:0] txData, rxData, got;
    logic [15:0] activeDivisor, seed;
    port_config_s portConfig;
    ring_event_s ringEvent;
    logic [7:0] sent[$];
    int miscompares = 0;
    int tests_run = 0;
    int cnt;
    int badStops = 0;
    always #5 clk = ~clk;
    // the error flag stands one cycle, so mid-cycle counting sees it once
    always @(negedge clk) badStops += (framingError === 1'b1);
    modem_control_serial_port #(.RING_CYCLES(RING), .DEPTH(16))
        modem_control_serial_port_i (.clk(clk), .reset_n(reset_n),
        .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
        .host_clear_in(host_clear_in), .module_ready_out(module_ready_out),
        .host_control_in(host_control_in), .asleep(asleep),
        .interface_on_out(interface_on_out), .interfaceOn(interfaceOn),
        .connection_active_out(connection_active_out),
        .ring_indicate_out(ring_indicate_out), .commandReady(commandReady),
        .connectionActive(connectionActive), .portConfig(portConfig),
        .ringEvent(ringEvent), .txValid(txValid), .txReady(txReady),
        .txData(txData), .rxValid(rxValid), .rxReady(rxReady),
        .rxData(rxData), .framingError(framingError),
        .hostControl(hostControl), .activeDivisor(activeDivisor));
    host_terminal_model #(.BIT_CYCLES(101)) host_terminal_model_i (
        .clk(clk), .serial_tx_out(serial_tx_out),
        .module_ready_out(module_ready_out), .serial_rx_in(serial_rx_in),
        .host_clear_in(host_clear_in), .host_control_in(host_control_in));
    function automatic logic [15:0] nextRand(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [15:0] expDivisor(input port_config_s c);
        logic [15:0] low;
        low = c.autoBaud ? 16'h0364 : 16'h0064;
        return (c.divisor < low) ? low : c.divisor;
    endfunction
    task automatic check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic sendTx(input logic [7:0] b);
        @(negedge clk);
        txValid = 1'b1;
        txData = b;
        for (int i = 0; i < 2000 && txReady !== 1'b1; i++) @(negedge clk);
        check(txReady === 1'b1, "tx stall");
        @(negedge clk);
        txValid = 1'b0;
        sent.push_back(b);
    endtask
    initial begin
        #900000;
        miscompares++;
        end_of_test();
    end
    initial begin
        reset_n = 1'b0;
        {interfaceOn, commandReady, connectionActive, asleep} = 4'h0;
        portConfig = '0;
        portConfig.divisor = 16'h0064;
        ringEvent = '0;
        {txValid, rxReady, txData} = '0;
        seed = 16'h0011;
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        repeat (8) @(negedge clk);
        // two corner divisors, then random ones
        for (int i = 0; i < 8; i++) begin
            seed = nextRand(seed);
            portConfig.divisor = (i < 2) ? 16'h0063 + i[15:0] : seed;
            portConfig.autoBaud = i[1];
            repeat (2) @(negedge clk);
            check(activeDivisor === expDivisor(portConfig), "rate");
        end
        portConfig = '0;
        portConfig.divisor = 16'h0064;
        for (int i = 0; i < 20; i++) begin
            seed = nextRand(seed);
            interfaceOn = seed[0];
            connectionActive = seed[1];
            @(negedge clk);
            check(interface_on_out === ~interfaceOn, "iface");
            check(connection_active_out === ~connectionActive, "dcd");
        end
        interfaceOn = 1'b1;
        repeat (2) @(negedge clk);
        check(module_ready_out === 1'b1, "early ready");
        commandReady = 1'b1;
        // ready must still be given while the core sleeps
        asleep = 1'b1;
        repeat (2) @(negedge clk);
        check(module_ready_out === 1'b0, "no ready");
        asleep = 1'b0;
        for (int i = 0; i < 2; i++) begin
            host_terminal_model_i.setLines(1'b1, i[0]);
            repeat (5) @(negedge clk);
            check(hostControl === ~i[0], "host control");
        end
        txValid = 1'b1;
        repeat (20) @(negedge clk);
        check(serial_tx_out === 1'b1 && txReady === 1'b0, "held");
        txValid = 1'b0;
        host_terminal_model_i.setLines(1'b0, 1'b1);
        sendTx(8'h00);
        sendTx(8'hff);
        for (int i = 0; i < 3; i++) begin
            seed = nextRand(seed);
            sendTx(seed[7:0]);
        end
        repeat (1200) @(negedge clk);
        check(host_terminal_model_i.gotBytes.size() == 5, "tx count");
        foreach (sent[i]) begin
            got = host_terminal_model_i.gotBytes[i];
            check(got === sent[i], "tx byte");
        end
        // fill to the almost-full mark with draining stalled
        sent.delete();
        for (int i = 0; i < 12; i++) begin
            seed = nextRand(seed);
            sent.push_back(seed[7:0]);
            host_terminal_model_i.sendByte(seed[7:0], 1'b1);
        end
        repeat (10) @(negedge clk);
        check(module_ready_out === 1'b1, "ready at fill");
        foreach (sent[i]) begin
            check(rxValid === 1'b1 && rxData === sent[i], "rx byte");
            rxReady = 1'b1;
            @(negedge clk);
            rxReady = 1'b0;
            @(negedge clk);
        end
        check(module_ready_out === 1'b0 && rxValid === 1'b0, "drain");
        // a frame with a low stop bit is flagged and dropped
        check(badStops == 0, "stop flagged");
        host_terminal_model_i.sendByte(8'h5a, 1'b0);
        repeat (200) @(negedge clk);
        check(badStops == 1 && rxValid === 1'b0, "stop error");
        // last pass has ringing switched off
        for (int k = 0; k < 4; k++) begin
            portConfig.ringEnable = (k < 3);
            ringEvent = 3'h1 << (k % 3);
            @(negedge clk);
            ringEvent = '0;
            cnt = 0;
            repeat (20) begin
                @(negedge clk);
                cnt += (ring_indicate_out === 1'b0);
            end
            check(cnt == ((k < 3) ? RING : 0), "ring");
        end
        end_of_test();
    end
endmodule
`default_nettype wire
